/* File: core/lmsp_cfg.svh */
// constants of the mission and scratchpad block
`ifndef LMSP_CFG_SVH
`define LMSP_CFG_SVH
`define LMSP_CLK_HZ 200000000
`define LMSP_SEC_CYCLES (`LMSP_CLK_HZ)
`define LMSP_SEC_PER_MIN 60
`define LMSP_SPAD_BYTES 32
`define LMSP_END_OFFSET_FULL 5'h1F
`define LMSP_ES_PF_BIT 5
`define LMSP_ES_ZERO_BIT 6
`define LMSP_ES_AA_BIT 7
`define LMSP_RATE_MIN 14'h0001
`define LMSP_RATE_MAX 14'h3FFF
`define LMSP_PWD_READ_VALUE 8'h00
`define LMSP_PWD_LO 16'h0228
`define LMSP_PWD_HI 16'h0237
`define LMSP_REG_PAGE_LO 16'h0200
`define LMSP_REG_PAGE_HI 16'h023F
`endif

/* File: core/lmsp_pkg.sv */
// types of the mission and scratchpad block
package lmsp_pkg;
  typedef enum logic [2:0] {
    LMSP_IDLE,
    LMSP_DELAY,
    LMSP_ALARM_WAIT,
    LMSP_ALARM_STAMP,
    LMSP_LOGGING,
    LMSP_FULL
  } lmsp_state_t;
endpackage : lmsp_pkg

/* File: core/lmsp_tick.sv */
// divider that produces one-cycle ticks of a programmable period
`timescale 1ns/10ps
module lmsp_tick #(
  parameter int W = 28
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic [W-1:0] period_i,
  output logic tick_o
);
  logic [W-1:0] cnt;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
      tick_o <= 1'b0;
    end else if (clr_i) begin
      cnt <= '0;
      tick_o <= 1'b0;
    end else if (en_i) begin
      if (cnt + W'(1) >= period_i) begin
        cnt <= '0;
        tick_o <= 1'b1;
      end else begin
        cnt <= cnt + W'(1);
        tick_o <= 1'b0;
      end
    end else begin
      tick_o <= 1'b0;
    end
  end
endmodule : lmsp_tick

/* File: core/lmsp_mission.sv */
// mission control, sample timing and scratchpad address registers
`timescale 1ns/10ps
`include "lmsp_cfg.svh"
module lmsp_mission
  import lmsp_pkg::*;
#(
  parameter int CLK_HZ = `LMSP_CLK_HZ,
  parameter int LOG_DEPTH = 8192,
  parameter int SEC_PER_MIN = `LMSP_SEC_PER_MIN
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // mission configuration and commands
  input wire logic temp_log_enable_i,
  input wire logic humidity_log_enable_i,
  input wire logic wrap_enable_i,
  input wire logic seconds_rate_select_i,
  input wire logic alarm_triggered_start_i,
  input wire logic [13:0] sample_rate_i,
  input wire logic [15:0] start_delay_min_i,
  input wire logic start_cmd_i,
  input wire logic stop_cmd_i,
  input wire logic clear_cmd_i,
  input wire logic rtc_osc_run_i,
  input wire logic [31:0] rtc_time_i,
  input wire logic temp_alarm_i,
  input wire logic alarm_enabled_tripped_i,
  // scratchpad write/read/copy
  input wire logic wr_start_i,
  input wire logic [7:0] ta_low_i,
  input wire logic [7:0] ta_high_i,
  input wire logic wr_byte_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_end_i,
  input wire logic [2:0] wr_bit_rem_i,
  input wire logic rd_start_i,
  input wire logic rd_next_i,
  input wire logic copy_i,
  input wire logic [7:0] auth_low_i,
  input wire logic [7:0] auth_high_i,
  input wire logic [7:0] auth_es_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic [7:0] mem_data_i,
  output logic [7:0] mem_rd_data_o,
  output logic [7:0] rd_byte_o,
  output logic [7:0] target_addr_low_o,
  output logic [7:0] target_addr_high_o,
  output logic [7:0] ending_offset_status_o,
  output logic copy_done_o,
  output logic [15:0] copy_addr_o,
  output logic [7:0] copy_data_o,
  output logic copy_we_o,
  output logic mission_active_o,
  output logic log_cleared_flag_o,
  output logic cond_search_o,
  output logic log_strobe_o,
  output logic measure_strobe_o,
  output logic [31:0] mission_stamp_o,
  output logic [23:0] mission_samples_o,
  output logic [23:0] device_samples_o
);
  localparam int LW = $clog2(LOG_DEPTH + 1);

  lmsp_state_t state;
  logic sec_tick;
  logic min_tick;
  logic [5:0] sec_in_min;
  logic [15:0] delay_cnt;
  logic [13:0] interval_cnt;
  logic [LW-1:0] entries;
  logic [7:0] spad [0:`LMSP_SPAD_BYTES-1];
  logic [4:0] wr_ptr;
  logic [4:0] end_off;
  logic partial;
  logic auth_ok;
  logic [1:0] rd_phase;
  logic [4:0] rd_ptr;
  logic copying;
  logic [4:0] cp_ptr;
  logic interval_tick;
  logic start_ok;
  logic copy_valid;
  logic reg_page;
  logic pwd_loc;

  // second tick from the core clock, minute tick counted from seconds
  lmsp_tick #(.W(28)) u_sec (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .clr_i(1'b0),
    .en_i(rtc_osc_run_i),
    .period_i(28'(CLK_HZ)),
    .tick_o(sec_tick)
  );

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sec_in_min <= '0;
      min_tick <= 1'b0;
    end else if (sec_tick) begin
      min_tick <= (sec_in_min == 6'(SEC_PER_MIN - 1));
      sec_in_min <= (sec_in_min == 6'(SEC_PER_MIN - 1)) ? '0
                    : sec_in_min + 6'd1;
    end else begin
      min_tick <= 1'b0;
    end
  end

  // rate zero is out of range; treated as one to keep the timer live
  always_comb begin
    interval_tick = seconds_rate_select_i ? sec_tick : min_tick;
  end

  assign start_ok = start_cmd_i && !mission_active_o &&
                    (temp_log_enable_i || humidity_log_enable_i);

  // mission sequencing
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= LMSP_IDLE;
      mission_active_o <= 1'b0;
      log_cleared_flag_o <= 1'b0;
      delay_cnt <= '0;
      interval_cnt <= '0;
      entries <= '0;
      mission_stamp_o <= '0;
      mission_samples_o <= '0;
      device_samples_o <= '0;
      log_strobe_o <= 1'b0;
      measure_strobe_o <= 1'b0;
    end else begin
      log_strobe_o <= 1'b0;
      measure_strobe_o <= 1'b0;
      if (clear_cmd_i && !mission_active_o) begin
        mission_stamp_o <= '0;
        mission_samples_o <= '0;
        entries <= '0;
        log_cleared_flag_o <= 1'b1;
      end
      if (stop_cmd_i) begin
        state <= LMSP_IDLE;
        mission_active_o <= 1'b0;
      end else begin
        case (state)
          LMSP_IDLE: begin
            if (start_ok) begin
              mission_active_o <= 1'b1;
              log_cleared_flag_o <= 1'b0;
              delay_cnt <= start_delay_min_i;
              interval_cnt <= '0;
              state <= LMSP_DELAY;
            end
          end
          LMSP_DELAY: begin
            if (delay_cnt == 16'h0000) begin
              if (alarm_triggered_start_i && temp_log_enable_i) begin
                state <= LMSP_ALARM_WAIT;
              end else begin
                mission_stamp_o <= rtc_time_i;
                log_strobe_o <= 1'b1;
                measure_strobe_o <= 1'b1;
                mission_samples_o <= mission_samples_o + 24'h00_0001;
                device_samples_o <= device_samples_o + 24'h00_0001;
                entries <= entries + LW'(1);
                state <= LMSP_LOGGING;
              end
            end else if (min_tick) begin
              delay_cnt <= delay_cnt - 16'h0001;
            end
          end
          LMSP_ALARM_WAIT, LMSP_ALARM_STAMP, LMSP_LOGGING: begin
            if (interval_tick) begin
              if (interval_cnt + 14'd1 >= sample_rate_i) begin
                interval_cnt <= '0;
                // a full log without wrap stops waking, saving the battery
                if (!(state == LMSP_LOGGING && !wrap_enable_i &&
                      entries >= LW'(LOG_DEPTH))) begin
                  measure_strobe_o <= 1'b1;
                  device_samples_o <= device_samples_o + 24'h00_0001;
                end
                if (state == LMSP_ALARM_WAIT) begin
                  if (temp_alarm_i) begin
                    log_strobe_o <= 1'b1;
                    entries <= entries + LW'(1);
                    state <= LMSP_ALARM_STAMP;
                  end
                end else if (state == LMSP_ALARM_STAMP) begin
                  mission_stamp_o <= rtc_time_i;
                  log_strobe_o <= 1'b1;
                  mission_samples_o <= mission_samples_o + 24'h00_0001;
                  entries <= entries + LW'(1);
                  state <= LMSP_LOGGING;
                end else if (entries >= LW'(LOG_DEPTH) &&
                             !wrap_enable_i) begin
                  state <= LMSP_FULL;
                end else begin
                  log_strobe_o <= 1'b1;
                  mission_samples_o <= mission_samples_o + 24'h00_0001;
                  entries <= (entries >= LW'(LOG_DEPTH)) ? LW'(1)
                             : entries + LW'(1);
                end
              end else begin
                interval_cnt <= interval_cnt + 14'd1;
              end
            end
          end
          LMSP_FULL: begin
            state <= LMSP_FULL;
          end
          default: begin
            state <= LMSP_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cond_search_o <= 1'b0;
    end else begin
      cond_search_o <= alarm_enabled_tripped_i;
    end
  end

  // scratchpad write and address registers
  assign copy_valid = copy_i && !copying &&
                      auth_low_i == target_addr_low_o &&
                      auth_high_i == target_addr_high_o &&
                      auth_es_i == ending_offset_status_o;
  assign reg_page = ({target_addr_high_o, target_addr_low_o}
                     >= `LMSP_REG_PAGE_LO) &&
                    ({target_addr_high_o, target_addr_low_o}
                     <= `LMSP_REG_PAGE_HI);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      target_addr_low_o <= '0;
      target_addr_high_o <= '0;
      wr_ptr <= '0;
      end_off <= '0;
      partial <= 1'b0;
    end else if (wr_start_i) begin
      target_addr_low_o <= ta_low_i;
      target_addr_high_o <= ta_high_i;
      wr_ptr <= ta_low_i[4:0];
      end_off <= ta_low_i[4:0];
      partial <= 1'b0;
    end else if (wr_byte_i) begin
      end_off <= wr_ptr;
      if (wr_ptr != `LMSP_END_OFFSET_FULL) begin
        wr_ptr <= wr_ptr + 5'd1;
      end
    end else if (wr_end_i) begin
      partial <= (wr_bit_rem_i != 3'd0);
    end
  end

  // the array has no reset; contents are undefined until written
  always_ff @(posedge clk_i) begin
    if (wr_byte_i) begin
      spad[wr_ptr] <= wr_data_i;
    end
  end

  // copy authorized: a valid copy beats a write in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      auth_ok <= 1'b0;
    end else if (copy_valid &&
                 end_off == `LMSP_END_OFFSET_FULL && !partial &&
                 !(reg_page && mission_active_o)) begin
      auth_ok <= 1'b1;
    end else if (wr_start_i || wr_byte_i) begin
      auth_ok <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ending_offset_status_o <= '0;
    end else begin
      ending_offset_status_o <= {auth_ok, 1'b0, partial, end_off};
    end
  end

  // copy engine walks the scratchpad from byte offset to ending offset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      copying <= 1'b0;
      cp_ptr <= '0;
      copy_we_o <= 1'b0;
      copy_addr_o <= '0;
      copy_data_o <= '0;
      copy_done_o <= 1'b0;
    end else begin
      copy_we_o <= 1'b0;
      copy_done_o <= 1'b0;
      if (copy_valid && end_off == `LMSP_END_OFFSET_FULL && !partial &&
          !(reg_page && mission_active_o)) begin
        copying <= 1'b1;
        cp_ptr <= target_addr_low_o[4:0];
        copy_addr_o <= {target_addr_high_o, target_addr_low_o};
      end else if (copying) begin
        copy_we_o <= 1'b1;
        copy_data_o <= spad[cp_ptr];
        if (copy_we_o) begin
          copy_addr_o <= copy_addr_o + 16'h0001;
        end
        if (cp_ptr == end_off) begin
          copying <= 1'b0;
          copy_done_o <= 1'b1;
        end else begin
          cp_ptr <= cp_ptr + 5'd1;
        end
      end
    end
  end

  // scratchpad read: address low, address high, status, then data
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_phase <= '0;
      rd_ptr <= '0;
      rd_byte_o <= '0;
    end else if (rd_start_i) begin
      rd_phase <= 2'd1;
      rd_ptr <= target_addr_low_o[4:0];
      rd_byte_o <= target_addr_low_o;
    end else if (rd_next_i) begin
      case (rd_phase)
        2'd1: begin
          rd_byte_o <= target_addr_high_o;
          rd_phase <= 2'd2;
        end
        2'd2: begin
          rd_byte_o <= ending_offset_status_o;
          rd_phase <= 2'd3;
        end
        2'd3: begin
          rd_byte_o <= spad[rd_ptr];
          rd_ptr <= rd_ptr + 5'd1;
        end
        default: begin
          rd_byte_o <= 8'hFF;
        end
      endcase
    end
  end

  // memory read path never blocked by a mission; passwords masked
  assign pwd_loc = (mem_addr_i >= `LMSP_PWD_LO) &&
                   (mem_addr_i <= `LMSP_PWD_HI);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_rd_data_o <= '0;
    end else begin
      mem_rd_data_o <= pwd_loc ? `LMSP_PWD_READ_VALUE : mem_data_i;
    end
  end
endmodule : lmsp_mission

/* File: verification/lmsp_mission_properties.sv */
// port assertions of the mission and scratchpad block
`timescale 1ns/10ps
module lmsp_mission_properties (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic temp_log_enable_i,
  input wire logic humidity_log_enable_i,
  input wire logic start_cmd_i,
  input wire logic stop_cmd_i,
  input wire logic wr_byte_i,
  input wire logic wr_end_i,
  input wire logic [2:0] wr_bit_rem_i,
  input wire logic copy_i,
  input wire logic [7:0] auth_low_i,
  input wire logic [7:0] auth_high_i,
  input wire logic [15:0] mem_addr_i,
  input logic [7:0] mem_rd_data_o,
  input logic [7:0] ending_offset_status_o,
  input logic copy_done_o,
  input logic copy_we_o,
  input logic mission_active_o,
  input logic log_cleared_flag_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_START_ACTIVE: assert property (start_cmd_i && !stop_cmd_i &&
    !mission_active_o && (temp_log_enable_i || humidity_log_enable_i)
    |=> mission_active_o && !log_cleared_flag_o)
    else $error("start did not raise the active flag");
  AST_NO_ENABLE_IDLE: assert property (!mission_active_o &&
    !temp_log_enable_i && !humidity_log_enable_i |=> !mission_active_o)
    else $error("mission armed with no logging enabled");
  AST_PWD_ZERO: assert property (mem_addr_i >= 16'h0228 &&
    mem_addr_i <= 16'h0237 |=> mem_rd_data_o == 8'h00)
    else $error("password bytes leaked on read");
  AST_PARTIAL_FLAG: assert property (wr_end_i && wr_bit_rem_i != 3'h0
    |-> ##[1:3] ending_offset_status_o[6:5] == 2'b01)
    else $error("partial byte flag missing");
  AST_AA_SET: assert property (copy_done_o
    |-> ##[1:2] ending_offset_status_o[7])
    else $error("copy done without authorized flag");
  AST_AA_CLEAR: assert property (wr_byte_i && !copy_i
    |-> ##[1:3] !ending_offset_status_o[7])
    else $error("write left authorized flag set");
  AST_COPY_FULL: assert property (copy_we_o
    |-> ending_offset_status_o[4:0] == 5'h1F)
    else $error("copy with short ending offset");
  AST_COPY_REFUSE: assert property (copy_i &&
    ending_offset_status_o[4:0] != 5'h1F |=> (!copy_we_o) [*4])
    else $error("copy ran with ending offset below 1Fh");
  AST_REG_PAGE: assert property (copy_i && mission_active_o &&
    auth_high_i == 8'h02 && auth_low_i < 8'h40 |=> (!copy_we_o) [*4])
    else $error("register page written during mission");
endmodule : lmsp_mission_properties

bind lmsp_mission lmsp_mission_properties lmsp_mission_properties_inst (.*);

/* File: verification/lmsp_host.sv */
// host model: mission setup and scratchpad transfers
`timescale 1ns/10ps
module lmsp_host (
  input wire logic clk_i,
  input wire logic [7:0] rd_byte_o,
  output logic temp_log_enable_i,
  output logic humidity_log_enable_i,
  output logic wrap_enable_i,
  output logic seconds_rate_select_i,
  output logic alarm_triggered_start_i,
  output logic [13:0] sample_rate_i,
  output logic [15:0] start_delay_min_i,
  output logic start_cmd_i,
  output logic stop_cmd_i,
  output logic clear_cmd_i,
  output logic rtc_osc_run_i,
  output logic wr_start_i,
  output logic [7:0] ta_low_i,
  output logic [7:0] ta_high_i,
  output logic wr_byte_i,
  output logic [7:0] wr_data_i,
  output logic wr_end_i,
  output logic [2:0] wr_bit_rem_i,
  output logic rd_start_i,
  output logic rd_next_i,
  output logic copy_i,
  output logic [7:0] auth_low_i,
  output logic [7:0] auth_high_i,
  output logic [7:0] auth_es_i
);
  initial begin
    {temp_log_enable_i, humidity_log_enable_i, wrap_enable_i} = '0;
    {seconds_rate_select_i, alarm_triggered_start_i, rtc_osc_run_i} = '0;
    {start_cmd_i, stop_cmd_i, clear_cmd_i, wr_start_i, wr_byte_i} = '0;
    {wr_end_i, wr_bit_rem_i, rd_start_i, rd_next_i, copy_i} = '0;
    {sample_rate_i, start_delay_min_i, ta_low_i, ta_high_i} = '0;
    {wr_data_i, auth_low_i, auth_high_i, auth_es_i} = '0;
  end

  task automatic step();
    @(posedge clk_i);
    #1;
  endtask : step

  // c: 0 start, 1 stop, 2 clear; each held for exactly one edge
  task automatic cmd(input int c);
    step();
    {start_cmd_i, stop_cmd_i, clear_cmd_i} = 3'b100 >> c;
    step();
    {start_cmd_i, stop_cmd_i, clear_cmd_i} = 3'b000;
  endtask : cmd

  task automatic setup(input logic te, he, wrap, sec, alarm,
                       input logic [13:0] rate, input logic [15:0] dly);
    cmd(2);
    rtc_osc_run_i = 1'b1;
    {temp_log_enable_i, humidity_log_enable_i} = {te, he};
    {wrap_enable_i, alarm_triggered_start_i} = {wrap, alarm};
    {seconds_rate_select_i, start_delay_min_i} = {sec, dly};
    step();
    sample_rate_i = rate;
  endtask : setup

  // byte k carries a0h + k so copied data can be traced back
  task automatic wr(input logic [7:0] lo, hi, input int n,
                    input logic [2:0] rem);
    step();
    {wr_start_i, ta_low_i, ta_high_i} = {1'b1, lo, hi};
    for (int k = 0; k < n; k++) begin
      step();
      {wr_start_i, wr_byte_i, wr_data_i} = {2'b01, 8'hA0 + k[7:0]};
    end
    step();
    {wr_start_i, wr_byte_i, wr_end_i, wr_bit_rem_i} = {3'b001, rem};
    step();
    wr_end_i = 1'b0;
  endtask : wr

  // read back before any copy so the flags can be judged first
  task automatic rdpre(output logic [7:0] a, b, c);
    step();
    rd_start_i = 1'b1;
    step();
    {rd_start_i, rd_next_i} = 2'b01;
    a = rd_byte_o;
    step();
    b = rd_byte_o;
    step();
    rd_next_i = 1'b0;
    c = rd_byte_o;
  endtask : rdpre

  task automatic copy(input logic [7:0] a, b, c);
    step();
    {copy_i, auth_low_i, auth_high_i, auth_es_i} = {1'b1, a, b, c};
    step();
    copy_i = 1'b0;
  endtask : copy
endmodule : lmsp_host

/* File: verification/lmsp_mission_test.sv */
// self-checking bench of the mission and scratchpad block
`timescale 1ns/10ps
module lmsp_mission_test;
  logic clk_i, rst_n_i, temp_log_enable_i, humidity_log_enable_i;
  logic wrap_enable_i, seconds_rate_select_i, alarm_triggered_start_i;
  logic start_cmd_i, stop_cmd_i, clear_cmd_i, rtc_osc_run_i, temp_alarm_i;
  logic alarm_enabled_tripped_i, wr_start_i, wr_byte_i, wr_end_i;
  logic rd_start_i, rd_next_i, copy_i, copy_done_o, copy_we_o;
  logic mission_active_o, log_cleared_flag_o, cond_search_o;
  logic log_strobe_o, measure_strobe_o;
  logic [2:0] wr_bit_rem_i;
  logic [13:0] sample_rate_i;
  logic [15:0] start_delay_min_i, mem_addr_i, copy_addr_o;
  logic [31:0] rtc_time_i, mission_stamp_o;
  logic [23:0] mission_samples_o, device_samples_o;
  logic [7:0] ta_low_i, ta_high_i, wr_data_i, auth_low_i, auth_high_i;
  logic [7:0] auth_es_i, mem_data_i, mem_rd_data_o, rd_byte_o;
  logic [7:0] target_addr_low_o, target_addr_high_o;
  logic [7:0] ending_offset_status_o, copy_data_o, pa, pb, pc;
  int n_mismatch, total_checks, got, waited, ncp;

  // short second and minute keep the run small: 10 and 30 cycles
  lmsp_mission #(.CLK_HZ(10), .LOG_DEPTH(4), .SEC_PER_MIN(3))
    lmsp_mission_inst (.*);
  lmsp_host lmsp_host_inst (.*);

  task automatic check(input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  // w: 0 log, 1 measure; must: running out of cycles is fatal
  task automatic wait_sig(input int w, lim, input bit must);
    got = 0;
    waited = 0;
    // waited ends as the number of edges up to and including the strobe
    while (waited < lim && got == 0) begin
      waited++;
      step(1);
      got = ((w == 0) ? log_strobe_o : measure_strobe_o) === 1'b1;
    end
    if (must && got == 0) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : wait_sig

  task automatic copy_run(input logic [7:0] a, b, c);
    lmsp_host_inst.copy(a, b, c);
    ncp = 0;
    repeat (12) begin
      step(1);
      if (copy_we_o === 1'b1) begin
        check(copy_addr_o, {b, a} + ncp);
        check(copy_data_o, 8'hA0 + ncp);
        ncp++;
      end
    end
  endtask : copy_run

  task automatic t_spad();
    lmsp_host_inst.wr(8'h3C, 8'h01, 4, 3'h0);
    step(3);
    check(ending_offset_status_o, 8'h1F);
    check({target_addr_high_o, target_addr_low_o}, 16'h013C);
    lmsp_host_inst.rdpre(pa, pb, pc);
    check({pa, pb, pc}, 24'h3C_011F);
    copy_run(pa, pb, pc);
    check(ncp, 4);
    check(ending_offset_status_o[7], 1'b1);
    lmsp_host_inst.wr(8'h3C, 8'h01, 1, 3'h0);
    step(3);
    check(ending_offset_status_o, 8'h1C);
    copy_run(8'h3C, 8'h01, 8'h1C);
    check(ncp, 0);
    lmsp_host_inst.wr(8'h00, 8'h01, 32, 3'h5);
    step(3);
    check(ending_offset_status_o, 8'h3F);
  endtask : t_spad

  task automatic t_mission();
    lmsp_host_inst.setup(0, 0, 0, 1, 0, 14'h0002, 16'h0001);
    lmsp_host_inst.cmd(0);
    step(2);
    check(mission_active_o, 1'b0);
    // humidity logging alone is enough to arm a mission
    lmsp_host_inst.setup(0, 1, 0, 1, 0, 14'h0002, 16'h0001);
    lmsp_host_inst.cmd(0);
    check({mission_active_o, log_cleared_flag_o}, 2'b10);
    wait_sig(0, 60, 1);
    step(2);
    check(mission_stamp_o, 32'h1234_5678);
    check(mission_samples_o, 24'h1);
    check(device_samples_o, 24'h1);
    // first log sits off the second boundary; time two later strobes
    wait_sig(0, 40, 1);
    wait_sig(0, 40, 1);
    check(waited, 20);
    {mem_addr_i, mem_data_i} = {16'h0100, 8'h5A};
    step(2);
    check(mem_rd_data_o, 8'h5A);
    mem_addr_i = 16'h0230;
    step(2);
    check(mem_rd_data_o, 8'h00);
    lmsp_host_inst.wr(8'h00, 8'h02, 32, 3'h0);
    step(3);
    copy_run(8'h00, 8'h02, 8'h1F);
    check(ncp, 0);
    check(ending_offset_status_o[7], 1'b0);
    repeat (3) wait_sig(0, 40, 0);
    wait_sig(0, 60, 0);
    check(got, 0);
    check(mission_samples_o, 24'h4);
    lmsp_host_inst.cmd(1);
  endtask : t_mission

  // wrap on here, so logging runs past the depth of four entries
  task automatic t_alarm();
    rtc_time_i = 32'h0000_BEEF;
    lmsp_host_inst.setup(1, 0, 1, 0, 1, 14'h0001, 16'h0000);
    lmsp_host_inst.cmd(0);
    wait_sig(1, 70, 1);
    step(2);
    check(device_samples_o, 24'h5);
    check(mission_samples_o, 24'h0);
    temp_alarm_i = 1'b1;
    wait_sig(0, 70, 1);
    step(2);
    check(mission_samples_o, 24'h0);
    check(mission_stamp_o, 32'h0);
    check(device_samples_o, 24'h6);
    wait_sig(0, 40, 1);
    check(waited + 2, 30);
    step(2);
    check(mission_stamp_o, 32'h0000_BEEF);
    check(mission_samples_o, 24'h1);
    repeat (4) wait_sig(0, 40, 1);
    step(2);
    check(mission_samples_o, 24'h5);
    alarm_enabled_tripped_i = 1'b1;
    step(2);
    check(cond_search_o, 1'b1);
    alarm_enabled_tripped_i = 1'b0;
    step(2);
    check(cond_search_o, 1'b0);
  endtask : t_alarm

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    {rst_n_i, temp_alarm_i, alarm_enabled_tripped_i} = 3'b000;
    {mem_addr_i, mem_data_i, rtc_time_i} = {24'h0, 32'h1234_5678};
    step(3);
    rst_n_i = 1'b1;
    t_spad();
    t_mission();
    t_alarm();
    report_and_stop();
  end
endmodule : lmsp_mission_test
